// >>> src/mam_pkg.sv
// Summary of operation
// - Program address is 24 bits, from PC otherwise
// - User accesses limited to lower program half
// - Table ops with page bit 7 reach configuration
// - Even lower word, odd upper, phantom byte zero
// - Fetch stays word aligned, PC steps by two
// - Lowest addresses reserved for execution vectors
// - Execution starts at address zero after reset
// - Primary and alternate interrupt vector tables
// - Separate read and write address generators
// - Data addresses are 16-bit byte addresses
// - Bit 15 selects RAM or program window
// - Reads outside implemented memory return zero
// - Low byte even address, high byte odd
// - Odd word access traps, write is suppressed
package mam_pkg;

    // ==========================================================
    // Widths
    localparam int PROG_AW = 24;
    localparam int PC_W = 23;
    localparam int DATA_AW = 16;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 8;
    localparam int PROG_DW = 24;

    // ==========================================================
    // Program space map
    localparam logic [23:0] RESET_TOP = 24'h00_0003;
    localparam logic [23:0] IVT_BASE = 24'h00_0004;
    localparam logic [23:0] IVT_TOP = 24'h00_00FF;
    localparam logic [23:0] ALT_BASE = 24'h00_0100;
    localparam logic [23:0] ALT_TOP = 24'h00_01FF;
    localparam logic [23:0] VEC_END = 24'h00_0200;
    localparam logic [23:0] USER_TOP = 24'h7F_FFFF;
    localparam logic [23:0] CFG_BASE = 24'hF8_0000;
    localparam logic [23:0] CFG_TOP = 24'hF8_0017;
    localparam logic [23:0] PARTID_BASE = 24'hFF_0000;
    localparam logic [23:0] PARTID_TOP = 24'hFF_FFFF;
    localparam int PAGE_CFG_BIT = 7;
    localparam int UPPER_HALF_BIT = 23;

    // ==========================================================
    // Program counter
    localparam logic [22:0] RESET_PC = 23'h00_0000;
    localparam logic [22:0] PC_STEP = 23'h00_0002;

    // ==========================================================
    // Data space
    localparam int EA_WIN_BIT = 15;
    localparam int RAM_BYTES_DEF = 30720;

    // ==========================================================
    // Program region codes
    typedef enum logic [2:0] {
        MAM_REG_RESET = 3'h0,
        MAM_REG_IVT = 3'h1,
        MAM_REG_ALT = 3'h2,
        MAM_REG_USER = 3'h3,
        MAM_REG_CFG = 3'h4,
        MAM_REG_PARTID = 3'h5,
        MAM_REG_RSVD = 3'h6,
        MAM_REG_DENIED = 3'h7
    } mam_region_t;

endpackage : mam_pkg

// >>> src/mam_ea_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mam_ea_if;
    logic [15:0] ea;
    logic req;
    logic word;
    logic ram_sel;
    logic win_sel;
    logic zero_sel;
    logic misalign;
    logic [1:0] byte_en;

    modport address_generator (
        output ea, req, word,
        input ram_sel, win_sel, zero_sel, misalign, byte_en
    );
    modport dec (
        input ea, req, word,
        output ram_sel, win_sel, zero_sel, misalign, byte_en
    );
endinterface : mam_ea_if
`default_nettype wire

// >>> src/mam_ea_decode.sv
`timescale 1ns/100ps
`default_nettype none
module mam_ea_decode #(
    parameter int RAM_BYTES = mam_pkg::RAM_BYTES_DEF
) (
    mam_ea_if.dec bus
);
    import mam_pkg::*;

    localparam logic [16:0] RAM_LIM = 17'(RAM_BYTES);

    logic upper;
    logic in_ram;

    // ==========================================================
    // Pure decode, no state: answers in the cycle of the address
    assign upper = bus.ea[EA_WIN_BIT];
    assign in_ram = !upper && ({1'b0, bus.ea} < RAM_LIM);
    assign bus.ram_sel = bus.req && in_ram;
    assign bus.win_sel = bus.req && upper;
    assign bus.zero_sel = bus.req && !upper && !in_ram;
    assign bus.misalign = bus.req && bus.word && bus.ea[0];

    // Even byte is the low lane, odd byte the high lane
    always_comb begin
        if (!bus.req) begin
            bus.byte_en = 2'b00;
        end else if (bus.word) begin
            bus.byte_en = 2'b11;
        end else if (bus.ea[0]) begin
            bus.byte_en = 2'b10;
        end else begin
            bus.byte_en = 2'b01;
        end
    end
endmodule : mam_ea_decode
`default_nettype wire

// >>> src/mam_addr_map.sv
`timescale 1ns/100ps
`default_nettype none
module mam_addr_map #(
    parameter int RAM_BYTES = mam_pkg::RAM_BYTES_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Program counter control
    input wire logic PC_INC,
    input wire logic PC_DEC,
    input wire logic PC_LOAD,
    input wire logic [mam_pkg::PC_W-1:0] PC_LOAD_ADDR,
    output logic [mam_pkg::PC_W-1:0] PC,
    // Table access
    input wire logic TABLE_READ_OP,
    input wire logic TABLE_WRITE_OP,
    input wire logic [mam_pkg::PAGE_W-1:0] TABLE_PAGE_REGISTER,
    input wire logic [15:0] TABLE_OFFSET,
    input wire logic [mam_pkg::PAGE_W-1:0] WINDOW_PAGE,
    // Program memory port
    output logic [mam_pkg::PROG_AW-1:0] PROG_ADDR,
    output logic [2:0] PROG_REGION,
    output logic PROG_DENIED,
    output logic PROG_IN_VECTORS,
    input wire logic [mam_pkg::PROG_DW-1:0] PROG_MEM_RDATA,
    output logic [15:0] PROG_WORD,
    // Read address generator
    input wire logic [mam_pkg::DATA_AW-1:0] RD_EFFECTIVE_ADDR,
    input wire logic RD_REQ,
    input wire logic RD_WORD,
    output logic RD_RAM_SEL,
    output logic RD_WINDOW_SEL,
    output logic RD_ZERO_SEL,
    output logic [mam_pkg::DATA_W-1:0] RD_DATA,
    output logic RD_DATA_VALID,
    // Write address generator
    input wire logic [mam_pkg::DATA_AW-1:0] WR_EFFECTIVE_ADDR,
    input wire logic WR_REQ,
    input wire logic WR_WORD,
    input wire logic [mam_pkg::DATA_W-1:0] WR_DATA,
    // Data RAM port
    output logic RAM_RD_EN,
    output logic [mam_pkg::DATA_AW-2:0] RAM_RD_ADDR,
    input wire logic [mam_pkg::DATA_W-1:0] RAM_RDATA,
    output logic RAM_WR_EN,
    output logic [mam_pkg::DATA_AW-2:0] RAM_WR_ADDR,
    output logic [1:0] RAM_WR_BE,
    output logic [mam_pkg::DATA_W-1:0] RAM_WR_DATA,
    // Trap
    output logic ADDR_ERR_TRAP
);
    import mam_pkg::*;

    logic [PC_W-1:0] pc_reg;
    logic [PROG_AW-1:0] prog_addr;
    logic table_op;
    logic cfg_ok;
    logic denied;
    mam_region_t region;
    logic prog_upper_reg;
    logic [15:0] prog_word_reg;
    logic rd_ram_reg;
    logic rd_win_reg;
    logic rd_byte_reg;
    logic rd_hi_reg;
    logic rd_pend_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic rd_valid_reg;
    logic [15:0] src_word;
    logic wr_en_reg;
    logic [DATA_AW-2:0] wr_addr_reg;
    logic [1:0] wr_be_reg;
    logic [DATA_W-1:0] wr_data_reg;
    logic trap_reg;

    mam_ea_if rd_bus ();
    mam_ea_if wr_bus ();

    // ==========================================================
    // Independent read and write address decode
    assign rd_bus.ea = RD_EFFECTIVE_ADDR;
    assign rd_bus.req = RD_REQ;
    assign rd_bus.word = RD_WORD;
    assign wr_bus.ea = WR_EFFECTIVE_ADDR;
    assign wr_bus.req = WR_REQ;
    assign wr_bus.word = WR_WORD;

    mam_ea_decode #(.RAM_BYTES(RAM_BYTES)) u_rd_dec (
        .bus(rd_bus)
    );
    mam_ea_decode #(.RAM_BYTES(RAM_BYTES)) u_wr_dec (
        .bus(wr_bus)
    );

    // ==========================================================
    // Program counter
    // Bit 0 is forced low so a load cannot misalign the fetch
    always_ff @(posedge CLK) begin
        if (RST) begin
            pc_reg <= RESET_PC;
        end else if (PC_LOAD) begin
            pc_reg <= {PC_LOAD_ADDR[PC_W-1:1], 1'b0};
        end else if (PC_INC) begin
            pc_reg <= pc_reg + PC_STEP;
        end else if (PC_DEC) begin
            pc_reg <= pc_reg - PC_STEP;
        end
    end
    assign PC = pc_reg;

    // ==========================================================
    // Program address source: table op, then window, then fetch
    assign table_op = TABLE_READ_OP || TABLE_WRITE_OP;
    always_comb begin
        if (table_op) begin
            prog_addr = {TABLE_PAGE_REGISTER, TABLE_OFFSET};
        end else if (rd_bus.win_sel) begin
            prog_addr = {1'b0, WINDOW_PAGE,
                RD_EFFECTIVE_ADDR[14:1], 1'b0};
        end else begin
            prog_addr = {1'b0, pc_reg};
        end
    end
    assign PROG_ADDR = prog_addr;

    // Upper half only for table ops with the page bit set
    assign cfg_ok = table_op && TABLE_PAGE_REGISTER[PAGE_CFG_BIT];
    assign denied = prog_addr[UPPER_HALF_BIT] && !cfg_ok;

    // ==========================================================
    // Program region decode, same cycle as the address
    always_comb begin
        if (denied) begin
            region = MAM_REG_DENIED;
        end else if (prog_addr <= RESET_TOP) begin
            region = MAM_REG_RESET;
        end else if (prog_addr >= IVT_BASE && prog_addr <= IVT_TOP) begin
            region = MAM_REG_IVT;
        end else if (prog_addr >= ALT_BASE && prog_addr <= ALT_TOP) begin
            region = MAM_REG_ALT;
        end else if (prog_addr <= USER_TOP) begin
            region = MAM_REG_USER;
        end else if (prog_addr >= CFG_BASE && prog_addr <= CFG_TOP) begin
            region = MAM_REG_CFG;
        end else if (prog_addr >= PARTID_BASE
                && prog_addr <= PARTID_TOP) begin
            region = MAM_REG_PARTID;
        end else begin
            region = MAM_REG_RSVD;
        end
    end
    assign PROG_REGION = region;
    assign PROG_DENIED = denied;
    assign PROG_IN_VECTORS = !denied && (prog_addr < VEC_END);

    // ==========================================================
    // Program word return, memory answers one cycle later
    always_ff @(posedge CLK) begin
        if (RST) begin
            prog_upper_reg <= 1'b0;
        end else begin
            prog_upper_reg <= prog_addr[0];
        end
    end

    // Phantom byte: upper word carries only bits 23..16
    always_ff @(posedge CLK) begin
        if (RST) begin
            prog_word_reg <= 16'h0000;
        end else if (prog_upper_reg) begin
            prog_word_reg <= {8'h00, PROG_MEM_RDATA[23:16]};
        end else begin
            prog_word_reg <= PROG_MEM_RDATA[15:0];
        end
    end
    assign PROG_WORD = prog_word_reg;

    // ==========================================================
    // Data read path
    // Misaligned reads still run so the instruction can complete
    assign RAM_RD_EN = rd_bus.ram_sel;
    assign RAM_RD_ADDR = RD_EFFECTIVE_ADDR[DATA_AW-1:1];
    assign RD_RAM_SEL = rd_bus.ram_sel;
    assign RD_WINDOW_SEL = rd_bus.win_sel;
    assign RD_ZERO_SEL = rd_bus.zero_sel;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_pend_reg <= 1'b0;
            rd_ram_reg <= 1'b0;
            rd_win_reg <= 1'b0;
            rd_byte_reg <= 1'b0;
            rd_hi_reg <= 1'b0;
        end else begin
            rd_pend_reg <= RD_REQ && !table_op;
            rd_ram_reg <= rd_bus.ram_sel;
            rd_win_reg <= rd_bus.win_sel && !table_op;
            rd_byte_reg <= !RD_WORD;
            rd_hi_reg <= RD_EFFECTIVE_ADDR[0];
        end
    end

    // Zero return costs no extra cycle: same latency as RAM
    always_comb begin
        if (rd_ram_reg) begin
            src_word = RAM_RDATA;
        end else if (rd_win_reg) begin
            src_word = prog_upper_reg ? {8'h00, PROG_MEM_RDATA[23:16]}
                                      : PROG_MEM_RDATA[15:0];
        end else begin
            src_word = 16'h0000;
        end
        if (rd_byte_reg) begin
            rd_data_next = {8'h00,
                rd_hi_reg ? src_word[15:8] : src_word[7:0]};
        end else begin
            rd_data_next = src_word;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_pend_reg;
            if (rd_pend_reg) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end
    assign RD_DATA = rd_data_reg;
    assign RD_DATA_VALID = rd_valid_reg;

    // ==========================================================
    // Data write path
    // Writes to the window or to unimplemented space are dropped
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_en_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_be_reg <= 2'b00;
            wr_data_reg <= 16'h0000;
        end else begin
            wr_en_reg <= wr_bus.ram_sel && !wr_bus.misalign;
            wr_addr_reg <= WR_EFFECTIVE_ADDR[DATA_AW-1:1];
            wr_be_reg <= wr_bus.misalign ? 2'b00 : wr_bus.byte_en;
            wr_data_reg <= WR_WORD ? WR_DATA
                                   : {WR_DATA[7:0], WR_DATA[7:0]};
        end
    end
    assign RAM_WR_EN = wr_en_reg;
    assign RAM_WR_ADDR = wr_addr_reg;
    assign RAM_WR_BE = wr_be_reg;
    assign RAM_WR_DATA = wr_data_reg;

    // ==========================================================
    // Address error trap, one pulse per faulting cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            trap_reg <= 1'b0;
        end else begin
            trap_reg <= rd_bus.misalign || wr_bus.misalign;
        end
    end
    assign ADDR_ERR_TRAP = trap_reg;

endmodule : mam_addr_map
`default_nettype wire

// >>> sim/mam_addr_map_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mam_addr_map_chk #(
    parameter int RAM_BYTES = mam_pkg::RAM_BYTES_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Program side
    input wire logic PC_INC,
    input wire logic PC_DEC,
    input wire logic PC_LOAD,
    input wire logic [mam_pkg::PC_W-1:0] PC,
    input wire logic TABLE_READ_OP,
    input wire logic TABLE_WRITE_OP,
    input wire logic [mam_pkg::PAGE_W-1:0] TABLE_PAGE_REGISTER,
    input wire logic [mam_pkg::PROG_AW-1:0] PROG_ADDR,
    input wire logic PROG_DENIED,
    input wire logic PROG_IN_VECTORS,
    // Data side
    input wire logic [mam_pkg::DATA_AW-1:0] RD_EFFECTIVE_ADDR,
    input wire logic RD_REQ,
    input wire logic RD_RAM_SEL,
    input wire logic RD_WINDOW_SEL,
    input wire logic RD_ZERO_SEL,
    input wire logic RD_DATA_VALID,
    input wire logic RAM_RD_EN,
    input wire logic [mam_pkg::DATA_AW-2:0] RAM_RD_ADDR,
    input wire logic [mam_pkg::DATA_AW-1:0] WR_EFFECTIVE_ADDR,
    input wire logic WR_REQ,
    input wire logic WR_WORD,
    input wire logic RAM_WR_EN,
    input wire logic [1:0] RAM_WR_BE,
    input wire logic ADDR_ERR_TRAP
);
    import mam_pkg::*;

    logic wr_odd_q;
    logic tbl;

    always_ff @(posedge CLK) begin
        wr_odd_q <= WR_EFFECTIVE_ADDR[0];
    end
    assign tbl = TABLE_READ_OP || TABLE_WRITE_OP;

    // ==========================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_pc_reset: assert property ($fell(RST) |-> PC == RESET_PC)
        else $error("pc not at zero after reset");
    a_pc_up: assert property (
        PC_INC && !PC_LOAD |=> PC == $past(PC) + PC_STEP)
        else $error("pc increment wrong");
    a_pc_down: assert property (PC_DEC && !PC_INC && !PC_LOAD
        |=> PC == $past(PC) - PC_STEP)
        else $error("pc decrement wrong");
    a_table_cfg_open: assert property (
        tbl && TABLE_PAGE_REGISTER[PAGE_CFG_BIT] |-> !PROG_DENIED)
        else $error("table access to config denied");
    a_vector_flag: assert property (PROG_IN_VECTORS ==
        (PROG_ADDR < VEC_END && !PROG_DENIED))
        else $error("vector area flag wrong");
    a_window_half: assert property (
        RD_REQ && RD_EFFECTIVE_ADDR[EA_WIN_BIT]
        |-> RD_WINDOW_SEL && !RD_RAM_SEL && !RD_ZERO_SEL)
        else $error("upper half not routed to window");
    a_ram_or_zero: assert property (
        RD_REQ && !RD_EFFECTIVE_ADDR[EA_WIN_BIT]
        |-> RD_RAM_SEL == (RD_EFFECTIVE_ADDR < RAM_BYTES)
        && RD_ZERO_SEL == !RD_RAM_SEL && !RD_WINDOW_SEL)
        else $error("ram or zero select wrong");
    a_ram_word_addr: assert property (RAM_RD_EN
        |-> RAM_RD_ADDR == RD_EFFECTIVE_ADDR[15:1])
        else $error("ram word address wrong");
    a_read_latency: assert property (
        RD_REQ && !tbl |-> ##2 RD_DATA_VALID)
        else $error("read result late");
    a_bad_word_write: assert property (
        WR_REQ && WR_WORD && WR_EFFECTIVE_ADDR[0]
        |=> ADDR_ERR_TRAP && !RAM_WR_EN)
        else $error("misaligned write not trapped");
    a_byte_lanes: assert property (WR_REQ && !WR_WORD
        && WR_EFFECTIVE_ADDR < RAM_BYTES
        |=> RAM_WR_EN && RAM_WR_BE == {wr_odd_q, !wr_odd_q})
        else $error("byte lane select wrong");
endmodule : mam_addr_map_chk

bind mam_addr_map mam_addr_map_chk #(.RAM_BYTES(RAM_BYTES)) u_chk (
    .CLK, .RST, .PC_INC, .PC_DEC, .PC_LOAD, .PC, .TABLE_READ_OP,
    .TABLE_WRITE_OP, .TABLE_PAGE_REGISTER, .PROG_ADDR, .PROG_DENIED,
    .PROG_IN_VECTORS, .RD_EFFECTIVE_ADDR, .RD_REQ, .RD_RAM_SEL,
    .RD_WINDOW_SEL, .RD_ZERO_SEL, .RD_DATA_VALID, .RAM_RD_EN, .RAM_RD_ADDR,
    .WR_EFFECTIVE_ADDR, .WR_REQ, .WR_WORD, .RAM_WR_EN, .RAM_WR_BE,
    .ADDR_ERR_TRAP
);
`default_nettype wire

// >>> sim/mam_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module mam_core_model (
    // Clock
    input wire logic CLK,
    // Program memory
    input wire logic [mam_pkg::PROG_AW-1:0] PROG_ADDR,
    output logic [mam_pkg::PROG_DW-1:0] PROG_MEM_RDATA,
    // Data memory
    input wire logic RAM_RD_EN,
    input wire logic [mam_pkg::DATA_AW-2:0] RAM_RD_ADDR,
    output logic [mam_pkg::DATA_W-1:0] RAM_RDATA
);
    import mam_pkg::*;

    // ==========================================================
    // Memories answer one cycle after the address
    always_ff @(posedge CLK) begin
        PROG_MEM_RDATA <= {8'h3C ^ PROG_ADDR[7:0],
            PROG_ADDR[15:0] ^ 16'h5A5A};
    end
    // Unselected ram toggles so a stale word cannot pass for zero
    always_ff @(posedge CLK) begin
        RAM_RDATA <= RAM_RD_EN ? {RAM_RD_ADDR[7:0] ^ 8'hC3, RAM_RD_ADDR[7:0]}
            : ~RAM_RDATA;
    end
endmodule : mam_core_model
`default_nettype wire

// >>> sim/memory_address_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
module memory_address_map_tb;
    logic CLK, RST, PC_INC, PC_DEC, PC_LOAD, TABLE_READ_OP, TABLE_WRITE_OP;
    logic RD_REQ, RD_WORD, RD_RAM_SEL, RD_WINDOW_SEL, RD_ZERO_SEL;
    logic RD_DATA_VALID, WR_REQ, WR_WORD, RAM_RD_EN, RAM_WR_EN;
    logic PROG_DENIED, PROG_IN_VECTORS, ADDR_ERR_TRAP;
    logic [22:0] PC_LOAD_ADDR, PC;
    logic [7:0] TABLE_PAGE_REGISTER, WINDOW_PAGE;
    logic [15:0] TABLE_OFFSET, RD_EFFECTIVE_ADDR, WR_EFFECTIVE_ADDR, WR_DATA;
    logic [15:0] PROG_WORD, RD_DATA, RAM_RDATA, RAM_WR_DATA;
    logic [23:0] PROG_ADDR, PROG_MEM_RDATA;
    logic [2:0] PROG_REGION;
    logic [14:0] RAM_RD_ADDR, RAM_WR_ADDR;
    logic [1:0] RAM_WR_BE;
    int fail_count, tests_run;

    mam_addr_map u_mam_addr_map (.CLK, .RST, .PC_INC, .PC_DEC, .PC_LOAD,
        .PC_LOAD_ADDR, .PC, .TABLE_READ_OP, .TABLE_WRITE_OP,
        .TABLE_PAGE_REGISTER, .TABLE_OFFSET, .WINDOW_PAGE, .PROG_ADDR,
        .PROG_REGION, .PROG_DENIED, .PROG_IN_VECTORS, .PROG_MEM_RDATA,
        .PROG_WORD, .RD_EFFECTIVE_ADDR, .RD_REQ, .RD_WORD, .RD_RAM_SEL,
        .RD_WINDOW_SEL, .RD_ZERO_SEL, .RD_DATA, .RD_DATA_VALID,
        .WR_EFFECTIVE_ADDR, .WR_REQ, .WR_WORD, .WR_DATA, .RAM_RD_EN,
        .RAM_RD_ADDR, .RAM_RDATA, .RAM_WR_EN, .RAM_WR_ADDR, .RAM_WR_BE,
        .RAM_WR_DATA, .ADDR_ERR_TRAP);
    mam_core_model u_mam_core_model (.CLK, .PROG_ADDR, .PROG_MEM_RDATA,
        .RAM_RD_EN, .RAM_RD_ADDR, .RAM_RDATA);

    initial CLK = 1'b0;
    always #2.5 CLK = ~CLK;

    // ==========================================================
    // Checking
    task automatic check(input string what, input logic [23:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    function automatic logic [15:0] ram_word(input logic [14:0] a);
        return {a[7:0] ^ 8'hC3, a[7:0]};
    endfunction : ram_word

    // ==========================================================
    // Scenarios
    task automatic t_pc();
        check("pc", PC, 0);
        check("region", PROG_REGION, 0);
        PC_INC = 1'b1;
        repeat (3) @(negedge CLK);
        PC_INC = 1'b0;
        PC_DEC = 1'b1;
        @(negedge CLK);
        PC_DEC = 1'b0;
        check("pc", PC, 4);
        {PC_LOAD, PC_INC} = 2'b11;
        PC_LOAD_ADDR = 23'h40_0201;
        @(negedge CLK);
        {PC_LOAD, PC_INC} = 2'b00;
        check("fetch addr", PROG_ADDR, 24'h40_0200);
        check("region", PROG_REGION, 3);
        repeat (2) @(negedge CLK);
        check("prog word", PROG_WORD, 16'h585A);
    endtask : t_pc

    task automatic t_map();
        logic [23:0] a[9] = '{24'h3, 24'h4, 24'hFF, 24'h100, 24'h1FF,
            24'h200, 24'hF8_0017, 24'hFF_0000, 24'h80_0000};
        logic [2:0] r[9] = '{0, 1, 1, 2, 2, 3, 4, 5, 6};
        for (int i = 0; i < 9; i++) begin
            @(negedge CLK);
            {TABLE_READ_OP, TABLE_WRITE_OP} = i[0] ? 2'b01 : 2'b10;
            {TABLE_PAGE_REGISTER, TABLE_OFFSET} = a[i];
            #1 check("region", PROG_REGION, r[i]);
            check("vectors", PROG_IN_VECTORS, a[i] < 24'h200);
            check("denied", PROG_DENIED, 0);
        end
        @(negedge CLK);
        {TABLE_PAGE_REGISTER, TABLE_OFFSET} = 24'h33;
        repeat (2) @(negedge CLK);
        check("upper word", PROG_WORD, 16'h000F);
        {TABLE_READ_OP, TABLE_WRITE_OP} = 2'b00;
    endtask : t_map

    task automatic rd(input logic [15:0] ea, input logic wd,
        input logic [15:0] exp);
        logic [2:0] sel;
        logic [2:0] got;
        sel = ea[15] ? 3'b010 : (ea < 16'h7800 ? 3'b100 : 3'b001);
        @(negedge CLK);
        {RD_EFFECTIVE_ADDR, RD_WORD, RD_REQ} = {ea, wd, 1'b1};
        #1 got = {RD_RAM_SEL, RD_WINDOW_SEL, RD_ZERO_SEL};
        check("sel", got, sel);
        @(negedge CLK);
        RD_REQ = 1'b0;
        check("trap", ADDR_ERR_TRAP, wd & ea[0]);
        check("valid", RD_DATA_VALID, 1'b0);
        @(negedge CLK);
        check("valid", RD_DATA_VALID, 1);
        check("rd data", RD_DATA, exp);
    endtask : rd

    task automatic t_read();
        WINDOW_PAGE = 8'h01;
        rd(16'h0010, 1, ram_word(15'h8));
        rd(16'h0010, 0, 16'h0008);
        rd(16'h0011, 0, 16'h00CB);
        rd(16'h0011, 1, ram_word(15'h8));
        rd(16'h7800, 1, 16'h0000);
        rd(16'h7FFF, 0, 16'h0000);
        rd(16'hFFFF, 0, 16'h00A5);
        rd(16'h8024, 1, 16'hDA7E);
    endtask : t_read

    task automatic wr(input logic [15:0] ea, input logic wd,
        input logic [15:0] d, input logic en, input logic [1:0] be,
        input logic [15:0] q);
        @(negedge CLK);
        {WR_EFFECTIVE_ADDR, WR_WORD, WR_DATA, WR_REQ} = {ea, wd, d, 1'b1};
        @(negedge CLK);
        WR_REQ = 1'b0;
        check("wr en", RAM_WR_EN, en);
        check("trap", ADDR_ERR_TRAP, wd & ea[0]);
        if (en) begin
            check("wr be", RAM_WR_BE, be);
            check("wr addr", RAM_WR_ADDR, ea[15:1]);
            check("wr data", RAM_WR_DATA, q);
        end
    endtask : wr

    task automatic t_write();
        wr(16'h0020, 0, 16'h00A5, 1, 2'b01, 16'hA5A5);
        wr(16'h0021, 0, 16'h003C, 1, 2'b10, 16'h3C3C);
        wr(16'h0022, 1, 16'h1234, 1, 2'b11, 16'h1234);
        wr(16'h0023, 1, 16'h1234, 0, 2'b00, 16'h0000);
        wr(16'h8000, 1, 16'h1234, 0, 2'b00, 16'h0000);
        wr(16'h7800, 1, 16'h1234, 0, 2'b00, 16'h0000);
    endtask : t_write

    task automatic t_dual();
        @(negedge CLK);
        {RD_EFFECTIVE_ADDR, RD_WORD, RD_REQ} = {16'h0040, 2'b11};
        {WR_EFFECTIVE_ADDR, WR_WORD, WR_DATA} = {16'h0062, 1'b1, 16'hBEEF};
        WR_REQ = 1'b1;
        #1 check("rd addr", RAM_RD_ADDR, 15'h20);
        @(negedge CLK);
        {RD_REQ, WR_REQ} = 2'b00;
        check("wr addr", RAM_WR_ADDR, 15'h31);
        @(negedge CLK);
        check("rd data", RD_DATA, ram_word(15'h20));
    endtask : t_dual

    initial begin
        {PC_INC, PC_DEC, PC_LOAD, TABLE_READ_OP, TABLE_WRITE_OP} = '0;
        {RD_REQ, RD_WORD, WR_REQ, WR_WORD, PC_LOAD_ADDR} = '0;
        {TABLE_PAGE_REGISTER, WINDOW_PAGE, TABLE_OFFSET} = '0;
        {RD_EFFECTIVE_ADDR, WR_EFFECTIVE_ADDR, WR_DATA} = '0;
        {fail_count, tests_run} = '0;
        RST = 1'b1;
        repeat (5) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        t_pc();
        t_map();
        t_read();
        t_write();
        t_dual();
        wrap_up();
    end

    // Whole run needs well under 200 cycles
    initial begin
        #5000;
        fail_count++;
        wrap_up();
    end
endmodule : memory_address_map_tb
`default_nettype wire
